// *** pkg/sfce_defines.vh ***
// constants for the servo fault code encoder
`ifndef SFCE_DEFINES_VH
`define SFCE_DEFINES_VH
// code patterns {bit3,bit2,bit1}
`define SFCE_CODE_NONE     3'h0
`define SFCE_CODE_B1B3     3'h5
`define SFCE_CODE_ALL      3'h7
`define SFCE_CODE_B1B2     3'h3
`define SFCE_CODE_B2B3     3'h6
`define SFCE_CODE_B2       3'h2
`define SFCE_CODE_B1       3'h1
// torque thresholds in percent of rated torque
`define SFCE_TORQUE_INST   9'h0F5
`define SFCE_TORQUE_CONT   9'h078
// converter conversion-done timeout, in us
`define SFCE_ADC_TIMEOUT_US 100
`define SFCE_CLK_MHZ        20
`define SFCE_ADC_TIMEOUT_CYC (`SFCE_ADC_TIMEOUT_US * `SFCE_CLK_MHZ)
// continuous overload dwell, in us
`define SFCE_CONT_OVL_US    1000000
`define SFCE_CONT_OVL_CYC   (`SFCE_CONT_OVL_US * `SFCE_CLK_MHZ)
// reset value of the warning code selection
`define SFCE_WARN_SEL_RST   1'h1
// fault index numbers: priority follows the order, lowest first
`define SFCE_NFAULT         27
`endif

// *** core/sfce_encoder.v ***
// servo fault code encoder: alarm latching, warning pick and code output
`timescale 1ns/100ps
`include "sfce_defines.vh"

// Contract
// R1: overspeed drives code bits one and three on, two off.
// R2: torque above 245% flags instantaneous overload, all code bits on.
// R3: torque held between 120% and 245% flags continuous overload, all bits on.
// R4: heat-sink, brake resistor, inrush resistor overloads report all bits on.
// R5: absolute encoder faults report all code bits off.
// R6: converter done timeout or control-system error raises alarm, bits off.
// R7: runaway and encoder faults drive bits one and three on.
// R8: deviation residual above overflow level raises alarm, bits one and two.
// R9: load deviation at or above limit raises alarm, bits one and two.
// R10: option unit removal raises alarm, bits two and three on.
// R11: main power missing phase raises alarm with only bit two.
// R12: low motor current or persistent blocking raises alarm, only bit two.
// R13: parameter unit transmit failure and timeout flag two errors, no code.
// R14: any active alarm drives the alarm output off.
// R15: any active warning drives the warning output off.
// R16: warning codes appear only when selection equals one; resets to one.
// R17: warning output appears only on an assigned terminal.
// R18: residual above scaled overflow level raises warning, code bits off.
// R19: overload warning before alarm threshold, only bit one on.
// R20: regeneration overload warning before alarm, only bit two on.
// R21: battery near alarm raises warning, bits one and two on.
// R22: alarm disables power stage; warning keeps operation running.
// R23: alarm reset clears cancellable alarms; power-cycle alarms stay.
// R24: latch alarm and code until reset; one fault by fixed priority.
module sfce_encoder #(
  parameter integer DEV_W        = 24,
  parameter integer TERM_N       = 3,
  parameter integer ADC_TIMEOUT  = `SFCE_ADC_TIMEOUT_CYC,
  parameter integer CONT_OVL_CYC = `SFCE_CONT_OVL_CYC
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // fault conditions from measurement logic (same clock)
  input  wire              overspeed,
  input  wire [8:0]        torque_pct,
  input  wire              heatsink_hot,
  input  wire              brake_res_ovl,
  input  wire              inrush_res_ovl,
  input  wire [5:0]        abs_enc_fault,
  input  wire              adc_start,
  input  wire              adc_done,
  input  wire              ctrl_sys_error,
  input  wire [4:0]        enc_fault,
  input  wire [DEV_W-1:0]  deviation_residual,
  input  wire [DEV_W-1:0]  deviation_overflow_level,
  input  wire [DEV_W-1:0]  load_deviation,
  input  wire [DEV_W-1:0]  motor_load_deviation_limit,
  input  wire              option_removed,
  input  wire              phase_missing,
  input  wire              motor_current_low,
  input  wire              blocked_while_on,
  input  wire              pu_no_transmit,
  input  wire              pu_timeout,
  input  wire              overload_near,
  input  wire              regen_overload_near,
  input  wire              battery_near,
  // configuration settings, held steady by their owner between writes
  // configuration
  input  wire [7:0]        deviation_warning_ratio,
  input  wire              warning_code_select_wr,
  input  wire              warning_code_select_in,
  input  wire [1:0]        warning_terminal_assign,
  // the alarm reset pin is sampled through two flip-flops below
  // external controller pins, asynchronous
  input  wire              alarm_reset_pin,
  // code and status outputs
  output reg               fault_code_bit1,
  output reg               fault_code_bit2,
  output reg               fault_code_bit3,
  output reg               alarm_out_n,
  output reg  [TERM_N-1:0] warning_term_n,
  output reg               power_stage_en,
  output reg               pu_tx_error1,
  output reg               pu_tx_error2,
  output reg               warning_code_select
);

  // fault slots run past the last used index so a new source can be
  // added without widening the priority pick or the latched index
  // (slots 25 and 26 are tied off below)
  localparam integer NF = `SFCE_NFAULT;

  // the code pattern is decoded again from the latched index rather than
  // stored, so the three pins can never disagree with the reported fault
  // while the alarm stands
  // code pattern of each fault index, priority by index (lowest wins)
  function [2:0] fault_code;
    input [4:0] idx;
    begin
      case (idx)
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04: fault_code = `SFCE_CODE_ALL;
        5'h05: fault_code = `SFCE_CODE_B1B3;
        5'h06, 5'h07, 5'h08, 5'h09, 5'h0A: fault_code = `SFCE_CODE_B1B3;
        5'h0B: fault_code = `SFCE_CODE_B1B2;
        5'h0C: fault_code = `SFCE_CODE_B1B2;
        5'h0D: fault_code = `SFCE_CODE_B2B3;
        5'h0E, 5'h0F, 5'h10: fault_code = `SFCE_CODE_B2;
        default: fault_code = `SFCE_CODE_NONE;
      endcase
    end
  endfunction

  // these faults describe lost absolute position or corrupt encoder data;
  // the reset pin must not hide them, only a full reset of the block does
  // power-cycle only faults: absolute encoder, multi-turn, encoder data
  function sticky_fault;
    input [4:0] idx;
    begin
      case (idx)
        5'h07, 5'h09, 5'h0A: sticky_fault = 1'b1;
        5'h11, 5'h12, 5'h13, 5'h14: sticky_fault = 1'b1;
        default: sticky_fault = 1'b0;
      endcase
    end
  endfunction

  // the reset pin comes from the controller's own clock; only the second
  // stage and its delayed copy feed logic, so a metastable first stage
  // never reaches the alarm latch. a held pin clears once, on its rise.
  // alarm reset pin synchroniser and rising edge
  reg rst_meta;
  reg rst_sync;
  reg rst_prev;
  always @(posedge core_clk) begin
    if (rst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      rst_prev <= 1'b0;
    end else begin
      rst_meta <= alarm_reset_pin;
      rst_sync <= rst_meta;
      rst_prev <= rst_sync;
    end
  end
  wire alarm_clear = rst_sync & ~rst_prev;

  // a new start restarts the count, so back-to-back conversions never
  // inherit time from the previous one; the timeout is a one-cycle pulse
  // that the alarm latch holds from then on
  // converter timeout: started conversion must finish within the limit
  reg [31:0] adc_cnt;
  reg        adc_busy;
  reg        adc_timeout;
  always @(posedge core_clk) begin
    if (rst) begin
      adc_cnt     <= 32'h0;
      adc_busy    <= 1'b0;
      adc_timeout <= 1'b0;
    end else begin
      adc_timeout <= 1'b0;
      if (adc_start) begin
        adc_busy <= 1'b1;
        adc_cnt  <= 32'h0;
      end else if (adc_busy) begin
        if (adc_done) begin
          adc_busy <= 1'b0;
        end else if (adc_cnt >= ADC_TIMEOUT - 1) begin
          adc_busy    <= 1'b0;
          adc_timeout <= 1'b1; // R6
        end else begin
          adc_cnt <= adc_cnt + 32'h1;
        end
      end
    end
  end

  // the dwell restarts whenever torque leaves the band, including a step
  // above the instant limit, which has its own higher-priority alarm.
  // the counter stops at its end value instead of wrapping, so a long
  // overload cannot drop the flag again
  // continuous overload dwell counter
  wire       torque_inst = torque_pct > `SFCE_TORQUE_INST; // R2
  wire       torque_band = (torque_pct >= `SFCE_TORQUE_CONT) && !torque_inst;
  reg [31:0] ovl_cnt;
  reg        cont_ovl;
  always @(posedge core_clk) begin
    if (rst) begin
      ovl_cnt  <= 32'h0;
      cont_ovl <= 1'b0;
    end else if (!torque_band) begin
      ovl_cnt  <= 32'h0;
      cont_ovl <= 1'b0;
    end else if (ovl_cnt >= CONT_OVL_CYC - 1) begin
      cont_ovl <= 1'b1; // R3
    end else begin
      ovl_cnt <= ovl_cnt + 32'h1;
    end
  end

  // the product is kept at full width before the divide so a large level
  // times a ratio above 100 percent does not wrap; the divide rounds down,
  // which places the warning at or just below the exact scaled level
  // scaled warning level: overflow level times percent ratio over 100
  wire [DEV_W+7:0] warn_prod  = deviation_overflow_level * deviation_warning_ratio;
  wire [DEV_W+7:0] warn_level = warn_prod / 32'd100;
  wire             dev_warn   = {8'h00, deviation_residual} > warn_level; // R18

  // one bit per fault source, lowest index has the highest priority.
  // the overloads come first because they threaten the power stage most;
  // absolute encoder, converter and control-system faults come last
  // fault vector in priority order
  wire [NF-1:0] fault_vec;
  assign fault_vec[0]     = torque_inst;                                 // R2
  assign fault_vec[1]     = cont_ovl;                                    // R3
  assign fault_vec[2]     = brake_res_ovl;                               // R4
  assign fault_vec[3]     = inrush_res_ovl;                              // R4
  assign fault_vec[4]     = heatsink_hot;                                // R4
  assign fault_vec[5]     = overspeed;                                   // R1
  assign fault_vec[10:6]  = enc_fault;                                   // R7
  assign fault_vec[11]    = deviation_residual > deviation_overflow_level; // R8
  assign fault_vec[12]    = load_deviation >= motor_load_deviation_limit;  // R9
  assign fault_vec[13]    = option_removed;                              // R10
  assign fault_vec[14]    = phase_missing;                               // R11
  assign fault_vec[15]    = motor_current_low;                           // R12
  assign fault_vec[16]    = blocked_while_on;                            // R12
  assign fault_vec[22:17] = abs_enc_fault;                               // R5
  assign fault_vec[23]    = adc_timeout;                                 // R6
  assign fault_vec[24]    = ctrl_sys_error;                              // R6
  assign fault_vec[26:25] = 2'h0;

  // the loop runs from the top index down so the last hit, the lowest
  // index, is what remains; nothing is latched here, only chosen
  // priority pick of the lowest active fault
  reg [4:0] pick_idx;
  reg       pick_any;
  integer   i;
  always @* begin
    pick_idx = 5'h00;
    pick_any = 1'b0;
    for (i = NF - 1; i >= 0; i = i - 1) begin
      if (fault_vec[i]) begin
        pick_idx = i[4:0]; // R24
        pick_any = 1'b1;
      end
    end
  end

  // an alarm latches on the first edge a fault is seen and then holds its
  // index even if the fault goes away. a clear edge re-reads the present
  // faults in the same cycle, so a fault still standing relatches at once
  // and a clear can never open a gap in the alarm output
  // latched alarm state
  reg       alarm_act;
  reg [4:0] alarm_idx;
  always @(posedge core_clk) begin
    if (rst) begin
      alarm_act <= 1'b0;
      alarm_idx <= 5'h00;
    end else if (!alarm_act) begin
      if (pick_any) begin
        alarm_act <= 1'b1; // R24
        alarm_idx <= pick_idx;
      end
    end else if (alarm_clear && !sticky_fault(alarm_idx)) begin
      alarm_act <= pick_any; // R23
      alarm_idx <= pick_idx;
    end
  end

  // the setting is a one-bit register loaded by a write strobe; it takes
  // effect on the code pins one cycle after the write
  // warning selection setting, resets to one
  always @(posedge core_clk) begin
    if (rst) begin
      warning_code_select <= `SFCE_WARN_SEL_RST; // R16
    end else if (warning_code_select_wr) begin
      warning_code_select <= warning_code_select_in;
    end
  end

  // warnings never latch: they follow their sources and vanish with them.
  // a deviation warning has an all-off code, so it wins the pick but
  // leaves the pins low while still driving the warning terminal
  // warning pick, deviation first
  reg [2:0] warn_code;
  reg       warn_any;
  always @* begin
    warn_any  = 1'b1;
    warn_code = `SFCE_CODE_NONE;
    if (dev_warn) begin
      warn_code = `SFCE_CODE_NONE; // R18
    end else if (overload_near) begin
      warn_code = `SFCE_CODE_B1;   // R19
    end else if (regen_overload_near) begin
      warn_code = `SFCE_CODE_B2;   // R20
    end else if (battery_near) begin
      warn_code = `SFCE_CODE_B1B2; // R21
    end else begin
      warn_any = 1'b0;
    end
  end

  // an alarm always owns the code pins; warnings show only with no alarm
  // standing and the selection set, otherwise the pins read all off
  // code output select
  reg [2:0] next_code;
  always @* begin
    if (alarm_act) begin
      next_code = fault_code(alarm_idx);
    end else if (warn_any && warning_code_select) begin
      next_code = warn_code; // R16
    end else begin
      next_code = `SFCE_CODE_NONE;
    end
  end

  // every pin leaves through a flip-flop so the controller sees clean
  // levels; alarm output, power stage and code change on the same edge.
  // the panel errors are plain mirrors of their sources, one cycle late,
  // and carry no code pattern
  // each warning terminal is low only when it is the assigned one
  // registered outputs
  integer t;
  always @(posedge core_clk) begin
    if (rst) begin
      fault_code_bit1 <= 1'b0;
      fault_code_bit2 <= 1'b0;
      fault_code_bit3 <= 1'b0;
      alarm_out_n     <= 1'b1;
      warning_term_n  <= {TERM_N{1'b1}};
      power_stage_en  <= 1'b0;
      pu_tx_error1    <= 1'b0;
      pu_tx_error2    <= 1'b0;
    end else begin
      fault_code_bit1 <= next_code[0];
      fault_code_bit2 <= next_code[1];
      fault_code_bit3 <= next_code[2];
      alarm_out_n     <= ~alarm_act;  // R14
      power_stage_en  <= ~alarm_act;  // R22
      pu_tx_error1    <= pu_no_transmit; // R13
      pu_tx_error2    <= pu_timeout;     // R13
      for (t = 0; t < TERM_N; t = t + 1) begin
        // unassigned terminals stay on
        warning_term_n[t] <= ~(warn_any && (warning_terminal_assign == t + 1)); // R15 R17
      end
    end
  end

endmodule // sfce_encoder

// *** bench/sfce_monitor.sv ***
// assertion checker bound to the fault code encoder
`timescale 1ns/100ps
`include "sfce_defines.vh"
module sfce_monitor #(
  parameter integer DEV_W  = 24,
  parameter integer TERM_N = 3
) (
  // clock, reset and watched inputs
  input wire              core_clk, rst, overspeed, heatsink_hot, brake_res_ovl,
  input wire              inrush_res_ovl, overload_near, alarm_reset_pin,
  input wire              pu_no_transmit, pu_timeout,
  input wire [8:0]        torque_pct,
  input wire [DEV_W-1:0]  deviation_residual,
  input wire [1:0]        warning_terminal_assign,
  // watched outputs
  input wire              fault_code_bit1, fault_code_bit2, fault_code_bit3,
  input wire              alarm_out_n, power_stage_en, pu_tx_error1, pu_tx_error2,
  input wire              warning_code_select,
  input wire [TERM_N-1:0] warning_term_n
);
  wire [2:0] code = {fault_code_bit3, fault_code_bit2, fault_code_bit1};
  // overspeed with nothing of higher priority beside it
  wire lone_ovs = overspeed && torque_pct < `SFCE_TORQUE_CONT &&
                  !(heatsink_hot | brake_res_ovl | inrush_res_ovl);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // long enough without reset pin that no clear is still pending
  sequence s_quiet;
    !alarm_reset_pin [*8];
  endsequence
  // alarm output idle on two samples
  sequence s_noalm;
    alarm_out_n [*2];
  endsequence
  property p_alm;
    overspeed |-> ##2 !alarm_out_n;
  endproperty
  a_alm: assert property (p_alm) else $error("alarm output missed a fault");
  property p_pwr;
    !alarm_out_n |-> !power_stage_en;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power stage on during alarm");
  property p_stab;
    s_quiet ##0 !alarm_out_n [*2] |-> $stable(code);
  endproperty
  a_stab: assert property (p_stab) else $error("latched code changed");
  property p_inst;
    $fell(alarm_out_n) && $past(torque_pct, 2) > `SFCE_TORQUE_INST |-> code == `SFCE_CODE_ALL;
  endproperty
  a_inst: assert property (p_inst) else $error("overload code wrong");
  property p_ovs;
    $fell(alarm_out_n) && $past(lone_ovs, 2) |-> code == `SFCE_CODE_B1B3;
  endproperty
  a_ovs: assert property (p_ovs) else $error("overspeed code wrong");
  property p_b1;
    overload_near && warning_code_select && deviation_residual == '0 ##1
      warning_code_select ##0 s_noalm |-> $past(code) == `SFCE_CODE_B1;
  endproperty
  a_b1: assert property (p_b1) else $error("overload warning code wrong");
  property p_wsel;
    !warning_code_select ##1 !warning_code_select ##0 s_noalm |-> $past(code) == 3'h0;
  endproperty
  a_wsel: assert property (p_wsel) else $error("warning code not hidden");
  property p_term;
    warning_terminal_assign == 2'h0 |=> &warning_term_n;
  endproperty
  a_term: assert property (p_term) else $error("unassigned terminal driven");
  property p_pu;
    pu_no_transmit || pu_timeout |=> {pu_tx_error2, pu_tx_error1} != 2'h0;
  endproperty
  a_pu: assert property (p_pu) else $error("panel error not flagged");
endmodule // sfce_monitor
bind sfce_encoder sfce_monitor #(.DEV_W(DEV_W), .TERM_N(TERM_N)) u_mon (.*);

// *** bench/sfce_ctrl_model.sv ***
// position controller model that pulses the alarm reset pin on request
`timescale 1ns/100ps
module sfce_ctrl_model (
  // clock, alarm seen and clear request
  input wire core_clk, alarm_out_n, clr_req,
  // reset pin toward the drive
  output reg alarm_reset_pin
);
  integer n = 0;
  initial alarm_reset_pin = 1'b0;
  // while asked and the alarm is seen, raise the pin for two cycles
  always @(negedge core_clk) begin
    if (n > 0) n <= n - 1;
    else if (clr_req && !alarm_out_n) n <= 3;
    alarm_reset_pin <= (n > 1);
  end
endmodule // sfce_ctrl_model

// *** bench/servo_fault_code_encoder_test.sv ***
// self-checking bench for the fault code encoder
`timescale 1ns/100ps
`include "sfce_defines.vh"
module servo_fault_code_encoder_test;
  localparam integer TO = 16;
  localparam integer CO = 20;
  // stimulus and bench state
  reg core_clk = 1'b0, rst = 1'b1, ast = 1'b0, wwr = 1'b0, win = 1'b0, clr = 1'b0, sel = 1'b1;
  reg  [19:0] f = 20'h0;
  reg  [8:0]  tq = 9'h0;
  reg  [23:0] res = 24'h0, ldv = 24'h0;
  reg  [7:0]  ratio = 8'h64;
  reg  [2:0]  wn = 3'h0, et;
  reg  [1:0]  pu = 2'h0, ta = 2'h0;
  reg  [31:0] rnd;
  reg         dn = 1'b0;
  wire        pin, b1, b2, b3, aln, pse, e1, e2, wsel;
  wire [2:0]  wt;
  wire [2:0]  c = {b3, b2, b1};
  integer     errors = 0, check_count = 0, i, k;
  // 50 ns clock
  always #25 core_clk = ~core_clk;
  sfce_encoder #(.DEV_W(24), .TERM_N(3), .ADC_TIMEOUT(TO), .CONT_OVL_CYC(CO)) DUT (
    .core_clk(core_clk), .rst(rst), .overspeed(f[0]), .torque_pct(tq),
    .heatsink_hot(f[1]), .brake_res_ovl(f[2]), .inrush_res_ovl(f[3]),
    .abs_enc_fault(f[19:14]), .adc_start(ast), .adc_done(dn), .ctrl_sys_error(f[8]),
    .enc_fault(f[13:9]), .deviation_residual(res), .deviation_overflow_level(24'h64),
    .load_deviation(ldv), .motor_load_deviation_limit(24'h10), .option_removed(f[4]),
    .phase_missing(f[5]), .motor_current_low(f[6]), .blocked_while_on(f[7]),
    .pu_no_transmit(pu[0]), .pu_timeout(pu[1]), .overload_near(wn[0]),
    .regen_overload_near(wn[1]), .battery_near(wn[2]), .deviation_warning_ratio(ratio),
    .warning_code_select_wr(wwr), .warning_code_select_in(win),
    .warning_terminal_assign(ta), .alarm_reset_pin(pin), .fault_code_bit1(b1),
    .fault_code_bit2(b2), .fault_code_bit3(b3), .alarm_out_n(aln), .warning_term_n(wt),
    .power_stage_en(pse), .pu_tx_error1(e1), .pu_tx_error2(e2), .warning_code_select(wsel));
  sfce_ctrl_model u_ctl (.core_clk(core_clk), .alarm_out_n(aln), .clr_req(clr),
    .alarm_reset_pin(pin));
  // expected alarm code of single fault j in bench bit order
  function [2:0] fcode(input integer j);
    fcode = (j == 0 || (j > 8 && j < 14)) ? `SFCE_CODE_B1B3 : (j < 4) ? `SFCE_CODE_ALL :
            (j == 4) ? `SFCE_CODE_B2B3 : (j < 8) ? `SFCE_CODE_B2 : `SFCE_CODE_NONE;
  endfunction
  // expected warning code by priority
  function [2:0] wcode(input [2:0] w);
    wcode = w[0] ? `SFCE_CODE_B1 : w[1] ? `SFCE_CODE_B2 : w[2] ? `SFCE_CODE_B1B2 : 3'h0;
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task rstp;
    begin
      rst = 1'b1;
      tick(1);
      rst = 1'b0;
      tick(1);
    end
  endtask
  // bounded wait for the alarm output
  task wait_alm(input integer lim);
    begin
      for (k = 0; k < lim && aln !== 1'b0; k = k + 1) tick(1);
      if (aln !== 1'b0) begin
        errors = errors + 1;
        tally_and_finish;
      end
    end
  endtask
  initial begin
    k = $urandom(39);
    tick(2);
    rst = 1'b0;
    tick(1);
    chk({aln, pse, wsel}, 3'h7);
    // each of the twenty bench fault flags in f alone
    for (i = 0; i < 20; i = i + 1) begin
      f = 20'h1 << i;
      wait_alm(4);
      tick(1);
      chk({c, pse}, {fcode(i), 1'b0});
      f = 20'h0;
      rstp;
    end
    // two faults at once: higher priority reported
    f = 20'h3;
    wait_alm(4);
    chk(c, `SFCE_CODE_ALL);
    f = 20'h0;
    rstp;
    // controller clears a cancellable alarm, not a sticky one
    f = 20'h1;
    wait_alm(4);
    f = 20'h0;
    clr = 1'b1;
    tick(10);
    chk({aln, c}, 4'h8);
    f = 20'h1 << 10;
    wait_alm(4);
    f = 20'h0;
    tick(10);
    chk(aln, 1'b0);
    clr = 1'b0;
    rstp;
    // torque above limit, and at limit only after the dwell
    tq = 9'h0F6;
    wait_alm(4);
    chk(c, `SFCE_CODE_ALL);
    tq = 9'h0F5;
    rstp;
    tick(CO - 4);
    chk(aln, 1'b1);
    wait_alm(12);
    chk(c, `SFCE_CODE_ALL);
    tq = 9'h0;
    rstp;
    // deviation overflow, then load deviation at limit
    res = 24'h65;
    wait_alm(4);
    chk(c, `SFCE_CODE_B1B2);
    res = 24'h0;
    ldv = 24'h10;
    rstp;
    wait_alm(4);
    chk(c, `SFCE_CODE_B1B2);
    ldv = 24'h0;
    rstp;
    // conversion that finishes in time raises nothing, one that times out alarms with no code
    ast = 1'b1;
    tick(1);
    ast = 1'b0;
    tick(4);
    dn = 1'b1;
    tick(1);
    dn = 1'b0;
    tick(TO + 6);
    chk({aln, pse}, 2'h3);
    ast = 1'b1;
    tick(1);
    ast = 1'b0;
    wait_alm(TO + 6);
    chk(c, `SFCE_CODE_NONE);
    rstp;
    // random warnings, selection, terminal and panel errors
    for (i = 0; i < 300; i = i + 1) begin
      rnd = $urandom;
      {win, pu, ta, wn} = rnd[7:0];
      ratio = rnd[15:8] % 8'h65;
      res = rnd[24] ? 24'h0 : {16'h0, rnd[23:16] % 8'h65};
      wwr = (i % 16) == 0;
      tick(1);
      if (wwr) sel = win;
      et = (sel && !(res > ratio)) ? wcode(wn) : 3'h0;
      if (!wwr) chk(c, et);
      et = ((|wn || res > ratio) && ta != 2'h0) ? ~(3'h1 << (ta - 2'h1)) : 3'h7;
      chk(wt, et);
      chk({aln, pse, wsel, e2, e1}, {2'h3, sel, pu});
    end
    tally_and_finish;
  end
endmodule // servo_fault_code_encoder_test
